//--- hdl/dpsr_pkg.sv
// Constants and carrier types for the dual-port synchronous SRAM port logic.
// Assumes one system clock shared by both ports and a synchronous reset.
package dpsr_pkg;
  localparam int ADDR_W = 16;
  localparam int LANE_W = 9;
  localparam int NUM_LANES = 2;
  localparam int DATA_W = LANE_W * NUM_LANES;
  localparam int NUM_PORTS = 2;
  localparam int WORDS = 65536;
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 18'h00000;
  localparam logic [NUM_LANES-1:0] LANES_NONE = 2'h0;
  localparam logic DIR_READ = 1'h1;
  localparam logic OUT_PIPE = 1'h1;

  // Pins of one port, as presented by the external controller
  typedef struct packed {
    logic port_sel_lo_n;
    logic port_sel_hi;
    logic hi_lane_sel_n;
    logic lo_lane_sel_n;
    logic rd_wr;
    logic out_en_n;
    logic addr_load_n;
    logic count_step_n;
    logic count_clear_n;
    logic out_latency_sel;
    logic [ADDR_W-1:0] word_addr;
    logic [DATA_W-1:0] data_lanes_in;
  } dpsr_pin_t;

  // Data pins driven back by one port
  typedef struct packed {
    logic [DATA_W-1:0] data_lanes_out;
    logic [NUM_LANES-1:0] data_lanes_oe;
  } dpsr_pout_t;

  // One stage of the select and read-request pipeline
  typedef struct packed {
    logic sel;
    logic rd;
  } dpsr_stage_t;
endpackage

//--- hdl/dpsr_port.sv
// Shared word array and the logic of both ports of a synchronous dual-port SRAM.
// Assumes all port inputs except out_en_n and out_latency_sel arrive synchronous
// to sys_clk; the data pins are resolved outside from the per-lane enables.
`timescale 1ns/10ps
`default_nettype none

module dpsr_port #(
  parameter bit NARROW_VARIANT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire dpsr_pkg::dpsr_pin_t [dpsr_pkg::NUM_PORTS-1:0] port_in,
  output logic [dpsr_pkg::NUM_PORTS-1:0][dpsr_pkg::DATA_W-1:0] data_lanes_out,
  output logic [dpsr_pkg::NUM_PORTS-1:0][dpsr_pkg::NUM_LANES-1:0] data_lanes_oe
);
  import dpsr_pkg::*;

  // Shared word array
  logic [DATA_W-1:0] mem_reg [WORDS];

  // Per-port address counter
  logic [ADDR_W-1:0] cnt_reg [NUM_PORTS];
  logic [ADDR_W-1:0] cnt_next [NUM_PORTS];

  // Per-port decoded request of this edge
  logic [NUM_LANES-1:0] lanes_now [NUM_PORTS];
  logic sel_now [NUM_PORTS];
  logic rd_now [NUM_PORTS];
  logic [NUM_LANES-1:0] wr_lanes [NUM_PORTS];
  logic [DATA_W-1:0] wr_data [NUM_PORTS];

  // Per-port control pipeline
  dpsr_stage_t stage1_reg [NUM_PORTS];
  dpsr_stage_t stage1_next [NUM_PORTS];
  dpsr_stage_t stage2_reg [NUM_PORTS];
  dpsr_stage_t stage2_next [NUM_PORTS];
  logic [NUM_LANES-1:0] lane_reg [NUM_PORTS];
  logic [NUM_LANES-1:0] lane_next [NUM_PORTS];

  // Per-port read data
  logic [DATA_W-1:0] flow_data_reg [NUM_PORTS];
  logic [DATA_W-1:0] flow_data_next [NUM_PORTS];
  logic [DATA_W-1:0] pipe_data_reg [NUM_PORTS];
  logic [DATA_W-1:0] pipe_data_next [NUM_PORTS];

  // Output stage selection
  logic drive_sel [NUM_PORTS];

  // Mask that clears the ninth bit of each lane in the narrow variant
  function automatic logic [DATA_W-1:0] lane_mask();
    logic [DATA_W-1:0] m;
    m = {DATA_W{1'b1}};
    if (NARROW_VARIANT) begin
      for (int l = 0; l < NUM_LANES; l++) begin
        m[l * LANE_W + LANE_W - 1] = 1'b0;
      end
    end
    return m;
  endfunction

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port

      // Address counter next value
      always_comb begin
        cnt_next[p] = cnt_reg[p];
        if (!port_in[p].count_clear_n) begin
          cnt_next[p] = ADDR_ZERO;
        end else if (!port_in[p].addr_load_n) begin
          cnt_next[p] = port_in[p].word_addr;
        end else if (!port_in[p].count_step_n) begin
          cnt_next[p] = cnt_reg[p] + ADDR_STEP;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          cnt_reg[p] <= ADDR_ZERO;
        end else begin
          cnt_reg[p] <= cnt_next[p];
        end
      end

      // Decode of the request presented at this edge
      always_comb begin
        lanes_now[p] = LANES_NONE;
        lanes_now[p][LANE_LO] = !port_in[p].lo_lane_sel_n;
        lanes_now[p][LANE_HI] = !port_in[p].hi_lane_sel_n;
        sel_now[p] = !port_in[p].port_sel_lo_n && port_in[p].port_sel_hi;
        rd_now[p] = sel_now[p] && (port_in[p].rd_wr == DIR_READ)
          && (lanes_now[p] != LANES_NONE);
        wr_lanes[p] = LANES_NONE;
        if (sel_now[p] && (port_in[p].rd_wr != DIR_READ)) begin
          wr_lanes[p] = lanes_now[p];
        end
        wr_data[p] = port_in[p].data_lanes_in & lane_mask();
      end

      // Select pipeline and lane register
      always_comb begin
        stage1_next[p].sel = sel_now[p];
        stage1_next[p].rd = rd_now[p];
        stage2_next[p] = stage1_reg[p];
        lane_next[p] = lanes_now[p];
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          stage1_reg[p] <= '0;
          stage2_reg[p] <= '0;
          lane_reg[p] <= LANES_NONE;
        end else begin
          stage1_reg[p] <= stage1_next[p];
          stage2_reg[p] <= stage2_next[p];
          lane_reg[p] <= lane_next[p];
        end
      end

      // Read data: flow stage holds until the next read, pipe stage one behind
      always_comb begin
        flow_data_next[p] = flow_data_reg[p];
        if (rd_now[p]) begin
          flow_data_next[p] = mem_reg[cnt_next[p]] & lane_mask();
        end
        pipe_data_next[p] = flow_data_reg[p];
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          flow_data_reg[p] <= DATA_ZERO;
          pipe_data_reg[p] <= DATA_ZERO;
        end else begin
          flow_data_reg[p] <= flow_data_next[p];
          pipe_data_reg[p] <= pipe_data_next[p];
        end
      end

      // Output lanes: chosen stage, lane register and asynchronous enable
      always_comb begin
        if (port_in[p].out_latency_sel == OUT_PIPE) begin
          drive_sel[p] = stage2_reg[p].sel && stage2_reg[p].rd;
          data_lanes_out[p] = pipe_data_reg[p];
        end else begin
          drive_sel[p] = stage1_reg[p].sel && stage1_reg[p].rd;
          data_lanes_out[p] = flow_data_reg[p];
        end
        data_lanes_oe[p] = LANES_NONE;
        if (drive_sel[p] && !port_in[p].out_en_n) begin
          data_lanes_oe[p] = lane_reg[p];
        end
      end
    end
  endgenerate

  // Shared array writes; the higher port wins a same-lane clash
  always_ff @(posedge sys_clk) begin
    for (int q = 0; q < NUM_PORTS; q++) begin
      for (int l = 0; l < NUM_LANES; l++) begin
        if (wr_lanes[q][l]) begin
          mem_reg[cnt_next[q]][l * LANE_W +: LANE_W] <=
            wr_data[q][l * LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- test/dpsr_port_asserts.sv
// Checker on port 0 of the dual-port SRAM, plus port 1 output gating.
// Bound to the port logic; sees only its pins.
`timescale 1ns/10ps
`default_nettype none
module dpsr_port_asserts (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire dpsr_pkg::dpsr_pin_t [1:0] port_in,
  input wire logic [1:0][17:0] data_lanes_out,
  input wire logic [1:0][1:0] data_lanes_oe
);
  import dpsr_pkg::*;
  dpsr_pin_t a;
  logic [1:0] o;
  logic f;
  assign a = port_in[0];
  assign o = data_lanes_oe[0];
  assign f = !a.out_latency_sel;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_oe_gate: assert property (a.out_en_n |-> o == 2'h0) else $error("oe0");
  a_gate_port1: assert property (port_in[1].out_en_n |-> data_lanes_oe[1] == 2'h0)
    else $error("oe1");
  a_desel_flow: assert property ((a.port_sel_lo_n && f) ##1 f |-> o == 2'h0)
    else $error("desel");
  a_desel_pipe: assert property (((a.port_sel_lo_n || !a.port_sel_hi) && !f) ##1 !f [*2]
    |-> o == 2'h0) else $error("desel2");
  a_lane_hi: assert property (a.hi_lane_sel_n |=> !o[1]) else $error("hi");
  a_lane_lo: assert property (a.lo_lane_sel_n |=> !o[0]) else $error("lo");
  a_write_quiet: assert property ((!a.rd_wr && f) ##1 f |-> o == 2'h0) else $error("wr");
  a_read_both: assert property ((!a.port_sel_lo_n && a.port_sel_hi && a.rd_wr && f &&
    {a.hi_lane_sel_n, a.lo_lane_sel_n} == 2'h0) ##1 (f && !a.out_en_n) |-> o == 2'h3)
    else $error("rd");
endmodule
bind dpsr_port dpsr_port_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .port_in(port_in),
  .data_lanes_out(data_lanes_out), .data_lanes_oe(data_lanes_oe));
`default_nettype wire

//--- test/dpsr_ctrl_model.sv
// Controller model driving the pins of one port.
// Assumes put is called just after a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module dpsr_ctrl_model (
  output var dpsr_pkg::dpsr_pin_t pins
);
  import dpsr_pkg::*;
  initial pins = {10'h3ee, ADDR_ZERO, DATA_ZERO};
  task put(input dpsr_pin_t v);
    pins = v;
  endtask
endmodule
`default_nettype wire

//--- test/dpsr_port_tb_top.sv
// Self-checking bench for the dual-port SRAM port logic.
// Assumes one controller model per port, driven off the falling edge.
`timescale 1ns/10ps
`default_nettype none
module dpsr_port_tb_top;
  import dpsr_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic lat = 1'h0;
  int err_count = 0;
  int n_compared = 0;
  dpsr_pin_t pi0;
  dpsr_pin_t pi1;
  dpsr_pin_t p;
  logic [1:0][17:0] dout;
  logic [1:0][1:0] oe;
  always #50 sys_clk = ~sys_clk;
  dpsr_ctrl_model m0 (.pins(pi0));
  dpsr_ctrl_model m1 (.pins(pi1));
  dpsr_port uut (.sys_clk(sys_clk), .rst_b(rst_b), .port_in({pi1, pi0}),
    .data_lanes_out(dout), .data_lanes_oe(oe));
  function automatic dpsr_pin_t idl();
    return {5'h1f, 1'h0, 3'h7, lat, ADDR_ZERO, DATA_ZERO};
  endfunction
  function automatic dpsr_pin_t rq(logic r, logic [1:0] l, logic [15:0] ad, logic [17:0] d);
    return {2'h1, l, r, 2'h0, 2'h3, lat, ad, d};
  endfunction
  task chk(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task go(input dpsr_pin_t v);
    @(negedge sys_clk);
    m0.put(v);
  endtask
  task test_done;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task t_rw;
    go(rq(1'h0, 2'h0, 16'h1234, 18'h2a5a5));
    go(rq(1'h0, 2'h2, 16'h1234, 18'h00033));
    go(rq(1'h1, 2'h0, 16'h1234, DATA_ZERO));
    go(rq(1'h1, 2'h1, 16'h1234, DATA_ZERO));
    chk(dout[0], 18'h2a433);
    chk(oe[0], 2'h3);
    go(idl());
    chk(oe[0], 2'h2);
  endtask
  task t_pipe;
    p = rq(1'h1, 2'h0, 16'h1234, DATA_ZERO);
    lat = 1'h1;
    go(rq(1'h1, 2'h0, 16'h1234, DATA_ZERO));
    m1.put(p);
    p = idl();
    p.hi_lane_sel_n = 1'h0;
    p.lo_lane_sel_n = 1'h0;
    go(p);
    chk(oe, 4'hc);
    chk(dout[1], 18'h2a433);
    go(idl());
    chk(oe[0], 2'h3);
    chk(dout[0], 18'h2a433);
    go(idl());
    chk(oe[0], 2'h0);
  endtask
  task t_cnt;
    lat = 1'h0;
    go(rq(1'h0, 2'h0, ADDR_ZERO, 18'h00011));
    go(rq(1'h0, 2'h0, ADDR_STEP, 18'h00022));
    p = idl();
    p.addr_load_n = 1'h0;
    p.word_addr = 16'hffff;
    go(p);
    p = idl();
    p.count_step_n = 1'h0;
    go(p);
    p = rq(1'h1, 2'h0, 16'h5555, DATA_ZERO);
    p.addr_load_n = 1'h1;
    go(p);
    p.count_step_n = 1'h0;
    go(p);
    chk(dout[0], 18'h00011);
    p.count_clear_n = 1'h0;
    p.addr_load_n = 1'h0;
    go(p);
    chk(dout[0], 18'h00022);
    go(idl());
    chk(dout[0], 18'h00011);
  endtask
  task t_oe;
    go(rq(1'h1, 2'h0, ADDR_STEP, DATA_ZERO));
    p = idl();
    p.out_en_n = 1'h1;
    go(p);
    #1;
    chk(oe[0], 2'h0);
    p.out_en_n = 1'h0;
    m0.put(p);
    #1;
    chk(oe[0], 2'h3);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_b = 1'h1;
    t_rw();
    t_pipe();
    t_cnt();
    t_oe();
    test_done();
  end
  initial begin
    repeat (200) @(posedge sys_clk);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
